// *** serdes_lane_sample_mapper.sv ***
// Behaviour
// - Format 11 packs 9-bit samples for 8B/10B on eight lanes (dual) or four (single).
// - Format 11 pads each sample with three zeros; lane k holds k..k+16 step 4 plus a tail.
// - Format 11 dual parts put channel B on lanes 4-7; single parts drive lanes 0-3 or 4-7 by lane set select.
// - Format 12 sends one 8-bit sample per lane per frame, A on lanes 0-3, B on lanes 4-7.
// - Format 12 uses eight lanes on dual, four on single, and is refused on quad parts.
// - Format 13 pads each sample with one zero; lane k holds k, k+4, k+8, k+12 in five octets.
// - Format 13 dual parts put B on lanes 4-7; only dual and single parts with 8 or 4 lanes.
// - Format 14 uses 8, 4 or 2 lanes for quad, dual, single; C on lanes 4-5, D on lanes 6-7.
// - Format 14 pads to 12 bits, two samples per lane: lane 0 A0 A2, lane 1 A1 A3.
// - Format 14 on dual or quad parts puts B0 B2 on lane 2 and B1 B3 on lane 3.
// - The active lane set follows the format, variant and lane set select; its rate follows only format and variant.
// - With four or fewer lanes, lane set select 0 drives lanes 0-3 and 1 drives lanes 4-7; with two lanes, 0 drives lanes 0-1 and 1 drives lanes 4-5.
`timescale 1ns/10ps
module serdes_lane_sample_mapper (
	input  wire logic                                          mclk,
	input  wire logic                                          reset,
	input  wire logic                                          clk_en,
	input  wire logic [3:0]                                    link_format_select,
	input  wire logic [1:0]                                    channel_variant,
	input  wire logic                                          lane_set_select,
	input  wire logic                                          sample_valid,
	input  wire logic [lane_map_pkg::CHAN_W-1:0]               chan_a_samples,
	input  wire logic [lane_map_pkg::CHAN_W-1:0]               chan_b_samples,
	input  wire logic [lane_map_pkg::SMALL_CHAN_W-1:0]         chan_c_samples,
	input  wire logic [lane_map_pkg::SMALL_CHAN_W-1:0]         chan_d_samples,
	output logic      [lane_map_pkg::LANES*lane_map_pkg::LANE_W-1:0] lane_data,
	output logic                                               lane_valid,
	output logic      [lane_map_pkg::LANES-1:0]                lane_enable,
	output logic                                               lane_coding_66b,
	output logic      [6:0]                                    lane_frame_bits,
	output logic                                               format_error
);
	logic [lane_map_pkg::LANES*lane_map_pkg::LANE_W-1:0]     lane_data_r;
	logic                                                    lane_valid_r;
	logic [lane_map_pkg::LANES-1:0]                          lane_enable_r;
	logic [lane_map_pkg::LANES-1:0]                          lane_enable_nxt;
	logic                                                    lane_coding_r;
	logic [6:0]                                              frame_bits_r;
	logic [6:0]                                              frame_bits_nxt;
	logic                                                    format_error_r;
	logic [3:0]                                              lane_count;
	logic [lane_map_pkg::LANES*lane_map_pkg::SLOT_BUS_W-1:0] slot_bus;
	logic [lane_map_pkg::LANES*lane_map_pkg::LANE_W-1:0]     packed_bus;

	function automatic logic [8:0] sample_at(
		input logic [lane_map_pkg::CHAN_W-1:0] vec,
		input int                              idx
	);
		sample_at = vec[idx*lane_map_pkg::SAMPLE_W +: lane_map_pkg::SAMPLE_W];
	endfunction : sample_at

	function automatic logic [3:0] lanes_for(
		input logic [3:0] fmt,
		input logic [1:0] variant
	);
		lanes_for = lane_map_pkg::LANES_NONE;
		if (fmt == lane_map_pkg::FMT_11 || fmt == lane_map_pkg::FMT_12 ||
				fmt == lane_map_pkg::FMT_13) begin
			if (variant == lane_map_pkg::VAR_DUAL) begin
				lanes_for = lane_map_pkg::LANES_EIGHT;
			end else if (variant == lane_map_pkg::VAR_SINGLE) begin
				lanes_for = lane_map_pkg::LANES_FOUR;
			end
		end else if (fmt == lane_map_pkg::FMT_14) begin
			if (variant == lane_map_pkg::VAR_QUAD) begin
				lanes_for = lane_map_pkg::LANES_EIGHT;
			end else if (variant == lane_map_pkg::VAR_DUAL) begin
				lanes_for = lane_map_pkg::LANES_FOUR;
			end else if (variant == lane_map_pkg::VAR_SINGLE) begin
				lanes_for = lane_map_pkg::LANES_TWO;
			end
		end
	endfunction : lanes_for

	assign lane_count = lanes_for(link_format_select, channel_variant);

	always_comb begin
		int                              logical;
		int                              ch;
		int                              idx;
		logic                            active;
		logic [lane_map_pkg::CHAN_W-1:0] src;
		logical         = 0;
		ch              = 0;
		idx             = 0;
		active          = 1'b0;
		src             = '0;
		slot_bus        = '0;
		lane_enable_nxt = lane_map_pkg::LANE_EN_RST;
		for (int p = 0; p < lane_map_pkg::LANES; p++) begin
			logical = p;
			active  = 1'b1;
			if (lane_count != lane_map_pkg::LANES_NONE &&
					lane_count <= lane_map_pkg::LANE_SET_SIZE) begin
				if (lane_set_select) begin
					active  = (p >= 4);
					logical = p - 4;
				end else begin
					active  = (p < 4);
				end
			end
			active = active && (logical >= 0) && (logical < int'(lane_count));
			lane_enable_nxt[p] = active;
			if (logical < 0) begin
				logical = 0;
			end
			if (link_format_select == lane_map_pkg::FMT_14) begin
				ch = logical / 2;
			end else begin
				ch = logical / 4;
			end
			case (ch)
				0: src = chan_a_samples;
				1: src = chan_b_samples;
				2: src = {144'h0, chan_c_samples};
				default: src = {144'h0, chan_d_samples};
			endcase
			for (int s = 0; s < lane_map_pkg::SLOTS; s++) begin
				if (link_format_select == lane_map_pkg::FMT_14) begin
					idx = (logical % 2) + 2 * s;
				end else begin
					idx = (logical % 4) + 4 * s;
				end
				if (active) begin
					slot_bus[(p*lane_map_pkg::SLOTS+s)*lane_map_pkg::SAMPLE_W +:
						lane_map_pkg::SAMPLE_W] = sample_at(src, idx);
				end
			end
		end
	end

	for (genvar g = 0; g < lane_map_pkg::LANES; g++) begin : g_lane
		lane_packer u_packer (
			.fmt         (link_format_select),
			.slots       (slot_bus[g*lane_map_pkg::SLOT_BUS_W +: lane_map_pkg::SLOT_BUS_W]),
			.packed_word (packed_bus[g*lane_map_pkg::LANE_W +: lane_map_pkg::LANE_W])
		);
	end

	always_comb begin
		case (link_format_select)
			lane_map_pkg::FMT_11: frame_bits_nxt = lane_map_pkg::FRAME_BITS_11;
			lane_map_pkg::FMT_12: frame_bits_nxt = lane_map_pkg::FRAME_BITS_12;
			lane_map_pkg::FMT_13: frame_bits_nxt = lane_map_pkg::FRAME_BITS_13;
			lane_map_pkg::FMT_14: frame_bits_nxt = lane_map_pkg::FRAME_BITS_14;
			default:              frame_bits_nxt = lane_map_pkg::FRAME_RST;
		endcase
	end

	// lane power and rate track the setting every enabled cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lane_enable_r  <= lane_map_pkg::LANE_EN_RST;
			lane_coding_r  <= 1'b0;
			frame_bits_r   <= lane_map_pkg::FRAME_RST;
			format_error_r <= 1'b0;
		end else if (clk_en) begin
			lane_enable_r  <= lane_enable_nxt;
			lane_coding_r  <= (link_format_select == lane_map_pkg::FMT_12) ||
				(link_format_select == lane_map_pkg::FMT_14);
			frame_bits_r   <= (lane_count == lane_map_pkg::LANES_NONE) ?
				lane_map_pkg::FRAME_RST : frame_bits_nxt;
			format_error_r <= (lane_count == lane_map_pkg::LANES_NONE);
		end
	end

	// a frame is taken only for a legal setting; lanes idle in that frame are written zero
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lane_data_r  <= lane_map_pkg::ALL_DATA_RST;
			lane_valid_r <= 1'b0;
		end else if (clk_en) begin
			lane_valid_r <= sample_valid && (lane_count != lane_map_pkg::LANES_NONE);
			if (sample_valid && lane_count != lane_map_pkg::LANES_NONE) begin
				for (int p = 0; p < lane_map_pkg::LANES; p++) begin
					lane_data_r[p*lane_map_pkg::LANE_W +: lane_map_pkg::LANE_W] <=
						lane_enable_nxt[p] ?
						packed_bus[p*lane_map_pkg::LANE_W +: lane_map_pkg::LANE_W] :
						lane_map_pkg::LANE_DATA_RST;
				end
			end
		end
	end

	assign lane_data       = lane_data_r;
	assign lane_valid      = lane_valid_r;
	assign lane_enable     = lane_enable_r;
	assign lane_coding_66b = lane_coding_r;
	assign lane_frame_bits = frame_bits_r;
	assign format_error    = format_error_r;
endmodule : serdes_lane_sample_mapper

// *** lane_map_pkg.sv ***
package lane_map_pkg;
	localparam int          SAMPLE_W      = 9;
	localparam int          SAMPLES_A     = 20;
	localparam int          SAMPLES_C     = 4;
	localparam int          SLOTS         = 5;
	localparam int          LANES         = 8;
	localparam int          LANE_W        = 64;
	localparam int          CHAN_W        = SAMPLE_W * SAMPLES_A;
	localparam int          SMALL_CHAN_W  = SAMPLE_W * SAMPLES_C;
	localparam int          SLOT_BUS_W    = SAMPLE_W * SLOTS;

	localparam logic [3:0]  FMT_11        = 4'hb;
	localparam logic [3:0]  FMT_12        = 4'hc;
	localparam logic [3:0]  FMT_13        = 4'hd;
	localparam logic [3:0]  FMT_14        = 4'he;

	localparam logic [1:0]  VAR_SINGLE    = 2'h0;
	localparam logic [1:0]  VAR_DUAL      = 2'h1;
	localparam logic [1:0]  VAR_QUAD      = 2'h2;

	localparam logic [3:0]  LANES_NONE    = 4'h0;
	localparam logic [3:0]  LANES_TWO     = 4'h2;
	localparam logic [3:0]  LANES_FOUR    = 4'h4;
	localparam logic [3:0]  LANES_EIGHT   = 4'h8;
	localparam logic [3:0]  LANE_SET_SIZE = 4'h4;

	localparam logic [6:0]  FRAME_BITS_11 = 7'h40;
	localparam logic [6:0]  FRAME_BITS_12 = 7'h08;
	localparam logic [6:0]  FRAME_BITS_13 = 7'h28;
	localparam logic [6:0]  FRAME_BITS_14 = 7'h18;

	// tail nibble content is not defined by the mapping; arbitrary constant
	localparam logic [3:0]  TAIL_NIBBLE   = 4'h0;

	localparam logic [LANE_W-1:0]       LANE_DATA_RST = 64'h0;
	localparam logic [LANES*LANE_W-1:0] ALL_DATA_RST  = 512'h0;
	localparam logic [LANES-1:0]        LANE_EN_RST   = 8'h00;
	localparam logic [6:0]              FRAME_RST     = 7'h00;
endpackage : lane_map_pkg

// *** lane_packer.sv ***
`timescale 1ns/10ps
module lane_packer (
	input  wire logic [3:0]                          fmt,
	input  wire logic [lane_map_pkg::SLOT_BUS_W-1:0] slots,
	output logic      [lane_map_pkg::LANE_W-1:0]     packed_word
);
	logic [8:0] s0;
	logic [8:0] s1;
	logic [8:0] s2;
	logic [8:0] s3;
	logic [8:0] s4;

	assign s0 = slots[8:0];
	assign s1 = slots[17:9];
	assign s2 = slots[26:18];
	assign s3 = slots[35:27];
	assign s4 = slots[44:36];

	// nibble 0 sits in the top bits so the word reads out first-sent first
	always_comb begin
		case (fmt)
			lane_map_pkg::FMT_11: begin
				packed_word = {s0, 3'h0, s1, 3'h0, s2, 3'h0, s3, 3'h0, s4, 3'h0,
					lane_map_pkg::TAIL_NIBBLE};
			end
			lane_map_pkg::FMT_12: begin
				packed_word = {s0[8:1], 56'h0};
			end
			lane_map_pkg::FMT_13: begin
				packed_word = {s0, 1'h0, s1, 1'h0, s2, 1'h0, s3, 1'h0, 24'h0};
			end
			lane_map_pkg::FMT_14: begin
				packed_word = {s0, 3'h0, s1, 3'h0, 40'h0};
			end
			default: begin
				packed_word = lane_map_pkg::LANE_DATA_RST;
			end
		endcase
	end
endmodule : lane_packer

// *** mapper_monitor.sv ***
`timescale 1ns/10ps
module mapper_monitor (
	input wire logic         mclk,
	input wire logic         reset,
	input wire logic         clk_en,
	input wire logic [3:0]   link_format_select,
	input wire logic [1:0]   channel_variant,
	input wire logic         lane_set_select,
	input wire logic         sample_valid,
	input wire logic [511:0] lane_data,
	input wire logic         lane_valid,
	input wire logic [7:0]   lane_enable,
	input wire logic         lane_coding_66b,
	input wire logic [6:0]   lane_frame_bits,
	input wire logic         format_error
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff reset;
	logic f11s;
	assign f11s = clk_en && link_format_select == 4'hb && channel_variant == 2'h0;
	sequence s_idle;
		clk_en && !sample_valid;
	endsequence
	sequence s_quad14;
		clk_en && sample_valid && link_format_select == 4'he && channel_variant == 2'h2;
	endsequence
	a_quad_all_lanes: assert property (s_quad14 |=> lane_valid && lane_enable == 8'hff)
		else $error("quad format 14 frame not on eight lanes");
	a_idle_no_valid: assert property (s_idle |=> !lane_valid && $stable(lane_data))
		else $error("lane output changed without a frame");
	// a held lane_valid under a low clock enable is not a new frame
	a_valid_cause: assert property ($past(clk_en) && lane_valid |-> $past(sample_valid))
		else $error("lane_valid without an offered frame");
	a_frozen_hold: assert property (!clk_en |=> $stable(lane_data) && $stable(lane_enable))
		else $error("outputs moved while clock enable low");
	a_quad_fmt12_ref: assert property (clk_en && link_format_select == 4'hc
		&& channel_variant == 2'h2 |=> format_error && lane_enable == 8'h00 && !lane_valid)
		else $error("format 12 on quad not refused");
	a_single_low_set: assert property (f11s && !lane_set_select |=> lane_enable == 8'h0f)
		else $error("lane set 0 not on lanes 0-3");
	a_single_high_set: assert property (f11s && lane_set_select |=> lane_enable == 8'hf0)
		else $error("lane set 1 not on lanes 4-7");
	a_fmt13_coding: assert property (clk_en && link_format_select == 4'hd
		|=> !lane_coding_66b)
		else $error("format 13 not on 8b10b coding");
	a_fmt11_bits: assert property (f11s |=> lane_frame_bits == 7'h40 && !format_error)
		else $error("format 11 frame length wrong");
endmodule : mapper_monitor
bind serdes_lane_sample_mapper mapper_monitor mapper_monitor_inst (.mclk(mclk), .reset(reset),
	.clk_en(clk_en), .link_format_select(link_format_select), .channel_variant(channel_variant),
	.lane_set_select(lane_set_select), .sample_valid(sample_valid), .lane_data(lane_data),
	.lane_valid(lane_valid), .lane_enable(lane_enable), .lane_coding_66b(lane_coding_66b),
	.lane_frame_bits(lane_frame_bits), .format_error(format_error));

// *** lane_receiver.sv ***
`timescale 1ns/10ps
module lane_receiver (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic [511:0] lane_data,
	input  wire logic         lane_valid,
	output logic      [511:0] rx_last,
	output logic      [15:0]  rx_count
);
	// receiver logic latches each delivered frame and counts them
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rx_last  <= 512'h0;
			rx_count <= 16'h0;
		end else if (lane_valid) begin
			rx_last  <= lane_data;
			rx_count <= rx_count + 16'h1;
		end
	end
endmodule : lane_receiver

// *** serdes_lane_sample_mapper_bench.sv ***
`timescale 1ns/10ps
module serdes_lane_sample_mapper_bench;
	logic mclk = 0, reset = 1, clk_en = 1, lane_set_select = 0, sample_valid = 0;
	logic [3:0] link_format_select = 4'hb;
	logic [1:0] channel_variant = 2'h1;
	logic [179:0] a = '0, b = '0;
	logic [35:0] c = '0, d = '0;
	logic [511:0] lane_data, rx_last, exp_d;
	logic lane_valid, lane_coding_66b, format_error;
	logic [7:0] lane_enable, exp_en;
	logic [6:0] lane_frame_bits, exp_fb;
	logic [15:0] rx_count;
	int n_fail = 0, comparisons = 0, cyc = 0;
	always #25 mclk = ~mclk;
	serdes_lane_sample_mapper serdes_lane_sample_mapper_inst (.mclk(mclk), .reset(reset),
		.clk_en(clk_en), .link_format_select(link_format_select), .channel_variant(channel_variant),
		.lane_set_select(lane_set_select), .sample_valid(sample_valid), .chan_a_samples(a),
		.chan_b_samples(b), .chan_c_samples(c), .chan_d_samples(d), .lane_data(lane_data),
		.lane_valid(lane_valid), .lane_enable(lane_enable), .lane_coding_66b(lane_coding_66b),
		.lane_frame_bits(lane_frame_bits), .format_error(format_error));
	lane_receiver lane_receiver_inst (.mclk(mclk), .reset(reset), .lane_data(lane_data),
		.lane_valid(lane_valid), .rx_last(rx_last), .rx_count(rx_count));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [511:0] e, input logic [511:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [8:0] smp(input int ch, input int i);
		return ch == 0 ? a[9*i+:9] : ch == 1 ? b[9*i+:9] : ch == 2 ? c[9*i+:9] : d[9*i+:9];
	endfunction : smp
	// expected lanes, left-justified, earliest sample in the top nibbles
	task automatic calc(input logic [3:0] f, input logic [1:0] v, input logic s);
		logic [63:0] w;
		logic [8:0] t;
		int n, k, j, off;
		n = f == 4'he ? (v == 2'h2 ? 8 : v == 2'h1 ? 4 : 2) : (v == 2'h1 ? 8 : 4);
		off = (s && n <= 4) ? 4 : 0;
		exp_d = '0;
		exp_en = 8'((1 << n) - 1) << off;
		exp_fb = f == 4'hb ? 7'h40 : f == 4'hc ? 7'h08 : f == 4'hd ? 7'h28 : 7'h18;
		for (k = 0; k < n; k++) begin
			w = '0;
			for (j = 0; j < 5; j++) begin
				if (f == 4'hb) w[63-12*j-:12] = {smp(k/4, k%4+4*j), 3'h0};
				if (f == 4'hd && j < 4) w[63-10*j-:10] = {smp(k/4, k%4+4*j), 1'h0};
				if (f == 4'he && j < 2) w[63-12*j-:12] = {smp(k/2, k%2+2*j), 3'h0};
			end
			t = smp(k/4, k%4);
			if (f == 4'hc) w[63:56] = t[8:1];
			if (f == 4'hb) w[3:0] = lane_map_pkg::TAIL_NIBBLE;
			exp_d[64*(k+off)+:64] = w;
		end
	endtask : calc
	task automatic offer(input logic [3:0] f, input logic [1:0] v, input logic s, input int k);
		logic [179:0] ta, tb;
		for (int i = 0; i < 20; i++) begin
			ta[9*i+:9] = 9'(i * 23 + k);
			tb[9*i+:9] = 9'(i * 41 + k) ^ 9'h155;
		end
		@(posedge mclk);
		link_format_select <= f;
		channel_variant <= v;
		lane_set_select <= s;
		sample_valid <= 1'b1;
		a <= ta;
		b <= tb;
		c <= ta[35:0] ^ 36'h5a5a5a5a5;
		d <= tb[35:0] ^ 36'h3c3c3c3c3;
		@(posedge mclk);
		sample_valid <= 1'b0;
		@(negedge mclk);
	endtask : offer
	task automatic run(input logic [3:0] f, input logic [1:0] v, input logic s);
		offer(f, v, s, 7);
		calc(f, v, s);
		chk("lane_data", exp_d, lane_data);
		chk("lane_valid", 1, lane_valid);
		chk("lane_enable", exp_en, lane_enable);
		chk("coding", f == 4'hc || f == 4'he, lane_coding_66b);
		chk("frame_bits", exp_fb, lane_frame_bits);
		chk("format_ok", 0, format_error);
		@(negedge mclk);
		chk("rx_last", exp_d, rx_last);
		chk("valid_pulse", 0, lane_valid);
	endtask : run
	task automatic refused(input logic [3:0] f, input logic [1:0] v);
		logic [511:0] prev;
		prev = lane_data;
		offer(f, v, 1'b0, 99);
		chk("refused_valid", 0, lane_valid);
		chk("refused_error", 1, format_error);
		chk("refused_enable", 0, lane_enable);
		chk("refused_data", prev, lane_data);
	endtask : refused
	task automatic frozen;
		logic [15:0] cnt;
		cnt = rx_count;
		@(posedge mclk);
		clk_en <= 1'b0;
		offer(4'he, 2'h2, 1'b0, 50);
		chk("frozen_valid", 0, lane_valid);
		chk("frozen_enable", 0, lane_enable);
		chk("frozen_error", 1, format_error);
		@(posedge mclk);
		clk_en <= 1'b1;
		@(negedge mclk);
		chk("frozen_count", cnt, rx_count);
	endtask : frozen
	initial begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		run(4'hb, 2'h1, 1'b0);
		run(4'hb, 2'h0, 1'b0);
		run(4'hb, 2'h0, 1'b1);
		run(4'hc, 2'h1, 1'b0);
		run(4'hc, 2'h0, 1'b1);
		run(4'hd, 2'h1, 1'b0);
		run(4'hd, 2'h0, 1'b0);
		run(4'he, 2'h2, 1'b0);
		run(4'he, 2'h1, 1'b1);
		run(4'he, 2'h0, 1'b0);
		refused(4'hc, 2'h2);
		refused(4'hb, 2'h2);
		refused(4'he, 2'h3);
		refused(4'h0, 2'h1);
		frozen();
		chk("rx_count", 10, rx_count);
		end_sim();
	end
endmodule : serdes_lane_sample_mapper_bench
